// File: common/hap_pkg.sv
// Package for the host access port: widths, timing constants, carriers, states
package hap_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int MEM_AW = 8;

  // Clock period in picoseconds, 50 MHz
  localparam int CLK_PERIOD_PS = 20000;
  // DT is the deviation of the clock period from 25 ns, in ps
  localparam int DT_PS = CLK_PERIOD_PS - 25000;

  // Least ready-low width for reads: 45 + 21DT/16 ns
  localparam int RD_LOW_MIN_PS = 45000 + (21 * DT_PS) / 16;
  // Least ready-low width for writes: 15 + 7DT/16 ns
  localparam int WR_LOW_MIN_PS = 15000 + (7 * DT_PS) / 16;
  // Least times round up to whole cycles, never below one
  localparam int RD_LOW_CYC_I = (RD_LOW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_LOW_CYC_I = (WR_LOW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] RD_LOW_CYC = 4'(RD_LOW_CYC_I < 1 ? 1 : RD_LOW_CYC_I);
  localparam logic [3:0] WR_LOW_CYC = 4'(WR_LOW_CYC_I < 1 ? 1 : WR_LOW_CYC_I);

  // Address bit that marks multiprocessor memory space when low
  localparam int MMS_BIT = 31;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] CNT_RST = 4'h0;

  // Host-side strobes, already active-low at the pins
  typedef struct packed {
    logic csN;
    logic busReqN;
    logic rdN;
    logic wrN;
  } hap_strobe_t;

  // Request toward internal memory
  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hap_memreq_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_DONE = 4'b1000
  } hap_state_t;

endpackage

// File: rtl/hap_port.sv
// Asynchronous host access port into internal memory
`timescale 1ns/100ps
module hap_port (
  input wire logic clock, // System clock, 50 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic openDrainMode, // 1 = ready open drain
  input wire hap_pkg::hap_strobe_t hostStrobe, // Host cs, request, rd, wr
  input wire logic [hap_pkg::ADDR_W-1:0] hostAddr, // Host address
  input wire logic [hap_pkg::DATA_W-1:0] hostDataIn, // Host write data
  input wire logic peerBusReqN, // Peer bus request, low active
  input wire logic corePriorityReqN, // Core priority request, low
  output logic hostBusGrantN, // Grant to host, low active
  output logic hostAccessReady, // Ready level output
  output logic hostAccessReadyOe, // Ready output enable
  output logic [hap_pkg::DATA_W-1:0] hostDataOut, // Read data
  output logic hostDataOe, // Data bus drive enable
  output logic memValid, // Memory request strobe
  output hap_pkg::hap_memreq_t memReq, // Memory request
  input wire logic [hap_pkg::DATA_W-1:0] memRdata // Memory read data, next cycle
);
  import hap_pkg::*;

  // ------------------------------------------------------------
  // Synchronisation of host strobes and peer and core requests
  // ------------------------------------------------------------
  hap_strobe_t syncStrobe;
  logic [1:0] syncReq;
  logic [3:0] syncStrobeBits;
  hap_sync #(.W(4), .RST(4'hf)) uStrobeSync (
    .clock(clock),
    .arst_n(arst_n),
    .din(hostStrobe),
    .dout(syncStrobeBits)
  );
  hap_sync #(.W(2), .RST(2'h3)) uReqSync (
    .clock(clock),
    .arst_n(arst_n),
    .din({peerBusReqN, corePriorityReqN}),
    .dout(syncReq)
  );
  assign syncStrobe = syncStrobeBits;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  hap_state_t state;
  hap_state_t next_state;
  logic [3:0] lowCnt;
  logic [3:0] next_lowCnt;
  logic hostOwns;
  logic rdActive;
  logic wrActive;
  logic addrLegal;
  logic readyLowMet;
  logic readDataValid;

  // Grant only when no peer or core priority request pending
  assign hostOwns = !syncStrobe.busReqN && !syncStrobe.csN && syncReq == 2'h3;
  assign rdActive = !hostBusGrantN && !syncStrobe.csN && !syncStrobe.rdN;
  assign wrActive = !hostBusGrantN && !syncStrobe.csN && !syncStrobe.wrN;
  // multiprocessor space addresses are not served
  assign addrLegal = hostAddr[MMS_BIT];
  assign readyLowMet = (state == ST_READ) ? (lowCnt >= RD_LOW_CYC) : (lowCnt >= WR_LOW_CYC);

  // Next state
  always_comb
  begin
    next_state = state;
    next_lowCnt = lowCnt;
    case (state)
      ST_IDLE:
      begin
        next_lowCnt = CNT_RST;
        if (rdActive)
          next_state = ST_READ;
        else if (wrActive)
          next_state = ST_WRITE;
      end
      ST_READ, ST_WRITE:
      begin
        if (lowCnt != 4'hf)
          next_lowCnt = lowCnt + 4'h1;
        if (readyLowMet && lowCnt >= 4'h2)
          next_state = ST_DONE;
      end
      ST_DONE:
      begin
        // wait for host to end its strobe
        if (syncStrobe.rdN && syncStrobe.wrN)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      lowCnt <= CNT_RST;
    end
    else
    begin
      state <= next_state;
      lowCnt <= next_lowCnt;
    end
  end

  // Grant follows the sampled request in ST_IDLE and is held through an access
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      hostBusGrantN <= 1'b1;
    else
      hostBusGrantN <= !hostOwns && state == ST_IDLE ? 1'b1 : hostBusGrantN && !hostOwns;
  end

  // Memory request issued on entry to an access
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      memValid <= 1'b0;
      memReq <= '0;
    end
    else
    begin
      memValid <= state == ST_IDLE && (rdActive || wrActive) && addrLegal;
      memReq.we <= !rdActive;
      memReq.addr <= hostAddr[MEM_AW-1:0];
      memReq.wdata <= hostDataIn;
    end
  end

  // read data captured one cycle after request
  assign readDataValid = state == ST_READ && lowCnt == 4'h1;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      hostDataOut <= DATA_RST;
    else if (readDataValid)
      hostDataOut <= addrLegal ? memRdata : DATA_RST;
  end

  // data driven only while the read strobe is low
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      hostDataOe <= 1'b0;
    else
      hostDataOe <= (state == ST_READ || state == ST_DONE) && !syncStrobe.rdN && lowCnt >= 4'h1
        || (state == ST_DONE && !syncStrobe.rdN);
  end

  // ------------------------------------------------------------
  // Ready output
  // ------------------------------------------------------------
  logic readyLow;
  // ready low as soon as an access starts
  assign readyLow = next_state == ST_READ || next_state == ST_WRITE;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hostAccessReady <= 1'b1;
      hostAccessReadyOe <= 1'b0;
    end
    else
    begin
      hostAccessReady <= !readyLow;
      hostAccessReadyOe <= readyLow || (!openDrainMode && !syncStrobe.csN);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence readyDrop_s;
    !hostAccessReady ##1 !hostAccessReady;
  endsequence

  readyOd_a: assert property (@(posedge clock) disable iff (!arst_n)
    openDrainMode && hostAccessReady |-> !hostAccessReadyOe)
    else $error("ready driven high in open-drain mode");

  readyLow_a: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_IDLE && next_state == ST_READ |=> !hostAccessReady && hostAccessReadyOe)
    else $error("ready not pulled low on access");

  readWidth_a: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(hostAccessReady) && state == ST_READ |-> readyDrop_s)
    else $error("read ready pulse too short");

  strobeGrant_a: assert property (@(posedge clock) disable iff (!arst_n)
    hostBusGrantN |=> state == ST_IDLE || $past(state) != ST_IDLE)
    else $error("access started without grant");

  dataBefore_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(hostAccessReady) && $past(state) == ST_READ |-> hostDataOe && $past(hostDataOe))
    else $error("read data not valid at ready release");

  dataOff_a: assert property (@(posedge clock) disable iff (!arst_n)
    syncStrobe.rdN && state == ST_IDLE |=> !hostDataOe)
    else $error("data bus driven after read strobe");

  readyHold_a: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_DONE |-> hostAccessReady)
    else $error("ready not released in done state");

  memIssue_a: assert property (@(posedge clock) disable iff (!arst_n)
    memValid |-> $past(state) == ST_IDLE)
    else $error("memory request outside access start");

endmodule // hap_port

// File: rtl/hap_sync.sv
// Two-flop synchroniser, one generate loop iteration per bit
`timescale 1ns/100ps
module hap_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic clock, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [W-1:0] din, // Asynchronous input
  output logic [W-1:0] dout // Synchronised output
);

  // ------------------------------------------------------------
  // Per-bit two-stage chain
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic stage1;
      // First stage feeds only the second
      always_ff @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage1 <= RST[i];
          dout[i] <= RST[i];
        end
        else
        begin
          stage1 <= din[i];
          dout[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule // hap_sync

// File: testbench/async_host_access_port_bench.sv
// Testbench for the host access port with host and memory models
`timescale 1ns/100ps
module async_host_access_port_bench;
  import hap_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic openDrainMode = 1'b0;
  logic peerBusReqN = 1'b1;
  logic corePriorityReqN = 1'b1;
  logic [DATA_W-1:0] memRdata = DATA_RST;
  logic [DATA_W-1:0] mem [256];
  logic [ADDR_W-1:0] hostAddr;
  logic [DATA_W-1:0] hostDataIn, hostDataOut;
  logic hostBusGrantN, hostAccessReady, hostAccessReadyOe, hostDataOe, memValid;
  logic oeAtRelease = 1'b0;
  hap_strobe_t hostStrobe;
  hap_memreq_t memReq;
  int failures = 0;
  int num_checks = 0;
  int memHits = 0;
  // Pull-up on ready, undriven data shows inverted bits
  wire logic readyPin = hostAccessReadyOe ? hostAccessReady : 1'b1;
  wire logic [DATA_W-1:0] dataPin = hostDataOe ? hostDataOut : ~hostDataOut;
  hap_port DUT (.clock, .arst_n, .openDrainMode, .hostStrobe, .hostAddr, .hostDataIn,
    .peerBusReqN, .corePriorityReqN, .hostBusGrantN, .hostAccessReady, .hostAccessReadyOe,
    .hostDataOut, .hostDataOe, .memValid, .memReq, .memRdata);
  hap_host_model host (.clock, .grantN(hostBusGrantN), .readyPin, .dataPin,
    .strobe(hostStrobe), .addr(hostAddr), .wdata(hostDataIn));
  // Clock at 50 MHz
  always #10 clock = ~clock;
  // Memory answers the cycle after a request; ready drive seen at release
  always @(posedge clock)
  begin
    if (memValid === 1'b1)
    begin
      memHits++;
      if (memReq.we === 1'b1)
        mem[memReq.addr] <= memReq.wdata;
      memRdata <= mem[memReq.addr];
    end
    if (readyPin === 1'b1 && hostStrobe.rdN === 1'b0)
      oeAtRelease <= hostAccessReadyOe;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_write_read(input logic mode, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic ok;
    int lowC, fallC, hits;
    @(posedge clock);
    #1;
    openDrainMode = mode;
    hits = memHits;
    host.access(1'b1, a, d, rd, lowC, fallC, ok);
    check("write done", ok, 1'b1); // granted access
    check("write ready fall", fallC <= 3, 1'b1); // prompt stall
    check("write ready low", lowC >= 3 && lowC >= WR_LOW_CYC, 1'b1); // width
    check("write landed", mem[a[7:0]], d); // synced access
    check("write requests", memHits - hits, 1); // single request
    host.access(1'b0, a, 32'h0, rd, lowC, fallC, ok);
    check("read data", rd, d); // data one cycle after release
    check("read ready fall", fallC <= 3, 1'b1); // prompt stall
    check("read ready low", lowC >= 3 && lowC >= RD_LOW_CYC, 1'b1); // width
    check("ready drive style", oeAtRelease, !mode); // drive style
    repeat (3) @(posedge clock);
    #1;
    check("data released", hostDataOe, 1'b0); // bus release
    $display("test write_read mode %0d done", mode);
  endtask
  task automatic t_refused();
    logic [31:0] rd;
    logic ok;
    int lowC, fallC, hits;
    hits = memHits;
    host.access(1'b1, 32'h0000_0020, 32'h1234_0001, rd, lowC, fallC, ok);
    host.access(1'b0, 32'h0000_0020, 32'h0, rd, lowC, fallC, ok);
    check("multiproc read", rd, DATA_RST); // space refused
    check("multiproc requests", memHits - hits, 0); // no access
    $display("test refused done");
  endtask
  task automatic t_blocked();
    logic [31:0] rd;
    logic ok;
    int lowC, fallC, hits;
    hits = memHits;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      #1;
      // peer request, then core priority request, asserted one per pass just after an edge
      peerBusReqN = k[0];
      corePriorityReqN = ~k[0];
      host.access(1'b1, 32'h8000_0044, 32'h1, rd, lowC, fallC, ok);
      check("grant blocked", ok, 1'b0); // request held off
      @(posedge clock);
      #1;
      peerBusReqN = 1'b1;
      corePriorityReqN = 1'b1;
    end
    check("blocked requests", memHits - hits, 0); // no memory requests
    host.access(1'b1, 32'h8000_0044, 32'h1, rd, lowC, fallC, ok);
    check("grant after release", ok, 1'b1); // granted once requests released
    $display("test blocked done");
  endtask
  // Watchdog cuts a hang short
  initial
  begin
    #(20 * 4000);
    failures++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    arst_n = 1'b1;
    check("reset outputs", {hostBusGrantN, readyPin, hostAccessReadyOe, hostDataOe, memValid},
      5'h18);
    $display("test reset done");
    for (int m = 0; m < 2; m++)
      t_write_read(m[0], 32'h8000_0010 + m, 32'hc3a5_0f00 + m);
    t_refused();
    t_blocked();
    give_verdict();
  end
endmodule // async_host_access_port_bench

// File: testbench/hap_host_model.sv
// Host processor model that requests the bus and strobes accesses
`timescale 1ns/100ps
module hap_host_model (
  input wire logic clock, // System clock
  input wire logic grantN, // Grant from port, low active
  input wire logic readyPin, // Resolved ready pin level
  input wire logic [31:0] dataPin, // Data bus seen by host
  output hap_pkg::hap_strobe_t strobe, // Host cs, request, rd, wr
  output logic [31:0] addr, // Host address
  output logic [31:0] wdata // Host write data
);
  import hap_pkg::*;
  // Idle strobes high, buses hold a pattern
  initial
  begin
    strobe = 4'hf;
    addr = 32'h5a5a_5a5a;
    wdata = 32'ha5a5_a5a5;
  end
  // One access; ok stays low if grant or ready never came
  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd, output int lowCyc, output int fallCyc, output logic ok);
    int n;
    ok = 1'b0;
    lowCyc = 0;
    fallCyc = 0;
    rd = 32'h0;
    @(posedge clock);
    #1;
    // fresh request once an earlier grant has gone, or after 20 cycles
    for (n = 0; n < 20 && grantN !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    strobe.csN = 1'b0;
    strobe.busReqN = 1'b0;
    for (n = 0; n < 20 && grantN !== 1'b0; n++)
    begin
      @(posedge clock);
      #1;
    end
    if (grantN === 1'b0)
    begin
      addr = a;
      wdata = d;
      @(posedge clock);
      #1;
      if (we)
        strobe.wrN = 1'b0;
      else
        strobe.rdN = 1'b0;
      while (readyPin !== 1'b0 && fallCyc < 20)
      begin
        @(posedge clock);
        #1;
        fallCyc++;
      end
      while (readyPin === 1'b0 && lowCyc < 30)
      begin
        @(posedge clock);
        #1;
        lowCyc++;
      end
      @(posedge clock);
      #1;
      rd = dataPin;
      ok = (lowCyc < 30) && (fallCyc < 20);
    end
    strobe = 4'hf;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // hap_host_model
